// ### iafps_defines.vh
// Constants for the in-application flash program sequencer.
// Assumes an 8-bit SFR bus with byte addresses as printed.
`ifndef IAFPS_DEFINES_VH
`define IAFPS_DEFINES_VH

// ==========================================
// SFR addresses
`define IAFPS_ADDR_KEY      8'hC7
`define IAFPS_ADDR_CHIPCTL  8'h9F
`define IAFPS_ADDR_TRIGGER  8'hA4
`define IAFPS_ADDR_UPDEN    8'hA5
`define IAFPS_ADDR_ALOW     8'hA6
`define IAFPS_ADDR_AHIGH    8'hA7
`define IAFPS_ADDR_FDATA    8'hAE
`define IAFPS_ADDR_CMD      8'hAF

// ==========================================
// Field positions
`define IAFPS_BIT_GO        0
`define IAFPS_BIT_ENABLE    0
`define IAFPS_BIT_FAULT     6
`define IAFPS_BIT_MAINUPD   0

// ==========================================
// Reset values
`define IAFPS_RST_FDATA     8'h00
`define IAFPS_RST_CMD       8'h30
`define IAFPS_RST_ADDR      8'h00

// ==========================================
// Keys and commands
`define IAFPS_KEY_FIRST     8'hAA
`define IAFPS_KEY_SECOND    8'h55
`define IAFPS_CMD_READ      8'h00
`define IAFPS_CMD_PROGRAM   8'h21
`define IAFPS_CMD_ERASE     8'h22

// ==========================================
// Timing, in ns, and page size
`define IAFPS_T_PROG_NS     2000
`define IAFPS_T_ERASE_NS    4000
`define IAFPS_CLK_NS        40
`define IAFPS_PAGE_BYTES    128

`endif

// ### iafps_flash_model.sv
// Flash array model: program clears bits, erase fills a page.
// Assumes level strobes from the sequencer on the system clock.
`timescale 1ns/100ps
module iafps_flash_model (
    // Clock
    input  wire        clk,
    // Array port
    input  wire [15:0] flashAddr,
    input  wire [7:0]  flashWdata,
    input  wire        flashProgram,
    input  wire        flashErase,
    output wire [7:0]  flashRdata
);
    reg [7:0] mem [0:32767];
    integer   i;
    initial begin
        for (i = 0; i < 32768; i = i + 1)
            mem[i] = i[7:0] ^ 8'hC3;
    end
    assign flashRdata = mem[flashAddr[14:0]];
    always @(posedge clk) begin
        if (flashProgram)
            mem[flashAddr[14:0]] <= mem[flashAddr[14:0]] & flashWdata;
        if (flashErase)
            for (i = 0; i < 128; i = i + 1)
                mem[{flashAddr[14:7], i[6:0]}] <= 8'hFF;
    end
endmodule

// ### iafps_key_unlock.v
// Timed-access key tracker: opens a one-write window after key pair.
// Assumes SFR write strobe on the system clock.
`timescale 1ns/100ps
`include "iafps_defines.vh"

module iafps_key_unlock (
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    input  wire       clkEn,
    // SFR write
    input  wire       sfrWr,
    input  wire [7:0] sfrAddr,
    input  wire [7:0] sfrWdata,
    // Window
    output wire       unlocked
);
    reg [1:0] stage_q;
    reg [1:0] stage_d;

    assign unlocked = (stage_q == 2'd2);

    // ==========================================
    // Key sequence
    always @* begin
        stage_d = stage_q;
        if (sfrWr) begin
            if (sfrAddr == `IAFPS_ADDR_KEY && sfrWdata == `IAFPS_KEY_FIRST) begin
                stage_d = 2'd1;
            end else if (sfrAddr == `IAFPS_ADDR_KEY && stage_q == 2'd1
                         && sfrWdata == `IAFPS_KEY_SECOND) begin
                stage_d = 2'd2;
            end else begin
                stage_d = 2'd0;
            end
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            stage_q <= 2'd0;
        end else if (clkEn) begin
            stage_q <= stage_d;
        end
    end
endmodule

// ### iafps_seq_asserts.sv
// Checker for the flash program sequencer, watching its ports only.
// Assumes it is bound into iafps_sequencer with clkEn held high.
`timescale 1ns/100ps
module iafps_seq_asserts #(
    parameter PROG_CYC  = 50,
    parameter ERASE_CYC = 100
) (
    input wire        clk,
    input wire        reset,
    input wire        sfrRd,
    input wire [7:0]  sfrAddr,
    input wire [7:0]  sfrRdata,
    input wire        extClkSel,
    input wire        cpuHold,
    input wire        fastRcOscOn,
    input wire [15:0] flashAddr,
    input wire        flashRead,
    input wire        flashProgram,
    input wire        flashErase
);
    // ========================================
    // Run length counter
    wire      anyOp = flashRead | flashProgram | flashErase;
    reg [7:0] runCnt_q;
    always @(posedge clk or posedge reset) begin
        if (reset)
            runCnt_q <= 8'h00;
        else
            runCnt_q <= (flashProgram | flashErase) ? runCnt_q + 8'h01 : 8'h00;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_stall; anyOp |-> cpuHold; endproperty
    a_stall: assert property (p_stall) else $error("op without stall");
    property p_stall_end; $fell(anyOp) |-> cpuHold ##1 !cpuHold; endproperty
    a_stall_end: assert property (p_stall_end) else $error("stall end wrong");
    property p_read_one; $rose(flashRead) |=> !flashRead; endproperty
    a_read_one: assert property (p_read_one) else $error("read too long");
    property p_prog_len; $fell(flashProgram) |-> runCnt_q == PROG_CYC; endproperty
    a_prog_len: assert property (p_prog_len) else $error("program length");
    property p_erase_len; $fell(flashErase) |-> runCnt_q == ERASE_CYC; endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase length");
    property p_page; flashErase |-> flashAddr[6:0] == 7'h00; endproperty
    a_page: assert property (p_page) else $error("erase not aligned");
    property p_osc; !extClkSel |=> fastRcOscOn; endproperty
    a_osc: assert property (p_osc) else $error("osc off");
    property p_trig_zero; sfrRd && sfrAddr == 8'hA4 |=> sfrRdata == 8'h00; endproperty
    a_trig_zero: assert property (p_trig_zero) else $error("trigger read");
endmodule

// ### iafps_sequencer.v
// In-application flash program sequencer: SFRs, key unlock, flash timing.
// Assumes a one-cycle SFR write strobe and combinational-free SFR read
// data, a simple flash array port, and a CPU that honours cpuHold.
// Summary of operation
// - Data byte is loaded before program; read result lands in it
// - Go bit write starts operation and holds the CPU until done
// - Go bit self-clears, reads zero; upper trigger bits reserved
// - Trigger write accepted only right after keys AAh then 55h
// - Clearing program enable stops fast RC osc when external clock used
// - Code lock bit never blocks read, program or erase
// - Command 21h programs a byte, 22h erases a main-array page
// - Address high byte gives bits 15:8, low byte bits 7:0
// - Page is 128 bytes; erase covers the whole addressed page
// - Bad address, bad command or disabled region sets fault flag
// - Setting program enable turns on the fast RC oscillator
`timescale 1ns/100ps
`include "iafps_defines.vh"

module iafps_sequencer #(
    parameter ARRAY_BYTES = 32768,
    parameter PROG_CYC    = (`IAFPS_T_PROG_NS + `IAFPS_CLK_NS - 1) / `IAFPS_CLK_NS,
    parameter ERASE_CYC   = (`IAFPS_T_ERASE_NS + `IAFPS_CLK_NS - 1) / `IAFPS_CLK_NS
) (
    // Clock and reset
    input  wire        clk,
    input  wire        reset,
    input  wire        clkEn,
    // SFR bus
    input  wire        sfrWr,
    input  wire        sfrRd,
    input  wire [7:0]  sfrAddr,
    input  wire [7:0]  sfrWdata,
    output reg  [7:0]  sfrRdata,
    // CPU and clocking
    input  wire        extClkSel,
    input  wire        codeLock,
    output reg         cpuHold,
    output reg         fastRcOscOn,
    // Flash array
    output reg  [15:0] flashAddr,
    output reg  [7:0]  flashWdata,
    input  wire [7:0]  flashRdata,
    output reg         flashRead,
    output reg         flashProgram,
    output reg         flashErase
);
    localparam ST_IDLE = 2'd0;
    localparam ST_RUN  = 2'd1;
    localparam ST_DONE = 2'd2;

    reg  [7:0]  dataByte_q;
    reg  [7:0]  cmd_q;
    reg  [7:0]  addrLow_q;
    reg  [7:0]  addrHigh_q;
    reg         progEnable_q;
    reg         mainUpd_q;
    reg         fault_q;
    reg  [1:0]  state_q;
    reg  [15:0] count_q;
    reg  [7:0]  runCmd_q;
    wire        unlocked;
    wire [15:0] targetAddr;
    wire        goWrite;
    wire        cmdValid;
    wire        needUpd;
    wire        badReq;

    // The codeLock input is intentionally not consulted anywhere.
    function isWr;
        input [7:0] a;
        begin
            isWr = sfrWr && (sfrAddr == a);
        end
    endfunction

    iafps_key_unlock uKey (
        .clk      (clk),
        .reset    (reset),
        .clkEn    (clkEn),
        .sfrWr    (sfrWr),
        .sfrAddr  (sfrAddr),
        .sfrWdata (sfrWdata),
        .unlocked (unlocked)
    );

    assign targetAddr = {addrHigh_q, addrLow_q};
    // Unkeyed write ignored
    // Inline decode: the function reads sfrWr and sfrAddr as globals
    assign goWrite    = sfrWr && (sfrAddr == `IAFPS_ADDR_TRIGGER) && unlocked
                        && sfrWdata[`IAFPS_BIT_GO] && state_q == ST_IDLE
                        && progEnable_q;
    assign cmdValid   = cmd_q == `IAFPS_CMD_READ || cmd_q == `IAFPS_CMD_PROGRAM
                        || cmd_q == `IAFPS_CMD_ERASE;
    assign needUpd    = cmd_q == `IAFPS_CMD_PROGRAM || cmd_q == `IAFPS_CMD_ERASE;
    assign badReq     = !cmdValid || ({16'h0000, targetAddr} >= ARRAY_BYTES)
                        || (needUpd && !mainUpd_q);

    // ==========================================
    // Registers and sequencer
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            dataByte_q   <= `IAFPS_RST_FDATA;
            cmd_q        <= `IAFPS_RST_CMD;
            addrLow_q    <= `IAFPS_RST_ADDR;
            addrHigh_q   <= `IAFPS_RST_ADDR;
            progEnable_q <= 1'b0;
            mainUpd_q    <= 1'b0;
            fault_q      <= 1'b0;
            state_q      <= ST_IDLE;
            count_q      <= 16'h0000;
            runCmd_q     <= 8'h00;
            cpuHold      <= 1'b0;
            fastRcOscOn  <= 1'b0;
            flashAddr    <= 16'h0000;
            flashWdata   <= 8'h00;
            flashRead    <= 1'b0;
            flashProgram <= 1'b0;
            flashErase   <= 1'b0;
            sfrRdata     <= 8'h00;
        end else if (clkEn) begin
            if (isWr(`IAFPS_ADDR_FDATA) && state_q == ST_IDLE) begin
                dataByte_q <= sfrWdata;
            end
            if (isWr(`IAFPS_ADDR_CMD)) begin
                cmd_q <= sfrWdata;
            end
            if (isWr(`IAFPS_ADDR_ALOW)) begin
                addrLow_q <= sfrWdata;
            end
            if (isWr(`IAFPS_ADDR_AHIGH)) begin
                addrHigh_q <= sfrWdata;
            end
            if (isWr(`IAFPS_ADDR_UPDEN) && unlocked) begin
                mainUpd_q <= sfrWdata[`IAFPS_BIT_MAINUPD];
            end
            if (isWr(`IAFPS_ADDR_CHIPCTL) && unlocked) begin
                progEnable_q <= sfrWdata[`IAFPS_BIT_ENABLE];
            end
            fastRcOscOn <= progEnable_q || !extClkSel;
            if (goWrite && badReq) begin
                fault_q <= 1'b1;
            end else if (isWr(`IAFPS_ADDR_CHIPCTL) && unlocked) begin
                fault_q <= sfrWdata[`IAFPS_BIT_FAULT];
            end
            case (state_q)
                ST_IDLE: begin
                    if (goWrite && !badReq) begin
                        state_q      <= ST_RUN;
                        cpuHold      <= 1'b1;
                        runCmd_q     <= cmd_q;
                        flashWdata   <= dataByte_q;
                        if (cmd_q == `IAFPS_CMD_ERASE) begin
                            flashAddr  <= {targetAddr[15:7], 7'h00};
                            flashErase <= 1'b1;
                            count_q    <= ERASE_CYC[15:0];
                        end else if (cmd_q == `IAFPS_CMD_PROGRAM) begin
                            flashAddr    <= targetAddr;
                            flashProgram <= 1'b1;
                            count_q      <= PROG_CYC[15:0];
                        end else begin
                            flashAddr <= targetAddr;
                            flashRead <= 1'b1;
                            count_q   <= 16'h0001;
                        end
                    end
                end
                ST_RUN: begin
                    if (count_q <= 16'h0001) begin
                        state_q      <= ST_DONE;
                        flashProgram <= 1'b0;
                        flashErase   <= 1'b0;
                        flashRead    <= 1'b0;
                    end else begin
                        count_q <= count_q - 16'h0001;
                    end
                end
                ST_DONE: begin
                    if (runCmd_q == `IAFPS_CMD_READ) begin
                        dataByte_q <= flashRdata;
                    end
                    state_q <= ST_IDLE;
                    cpuHold <= 1'b0;
                end
                default: begin
                    state_q <= ST_IDLE;
                    cpuHold <= 1'b0;
                end
            endcase
            // Read mux; trigger reads zero
            if (sfrRd) begin
                if (sfrAddr == `IAFPS_ADDR_FDATA) begin
                    sfrRdata <= dataByte_q;
                end else if (sfrAddr == `IAFPS_ADDR_CMD) begin
                    sfrRdata <= cmd_q;
                end else if (sfrAddr == `IAFPS_ADDR_ALOW) begin
                    sfrRdata <= addrLow_q;
                end else if (sfrAddr == `IAFPS_ADDR_AHIGH) begin
                    sfrRdata <= addrHigh_q;
                end else if (sfrAddr == `IAFPS_ADDR_UPDEN) begin
                    sfrRdata <= {7'h00, mainUpd_q};
                end else if (sfrAddr == `IAFPS_ADDR_CHIPCTL) begin
                    sfrRdata <= {1'b0, fault_q, 5'h00, progEnable_q};
                end else begin
                    sfrRdata <= 8'h00;
                end
            end
        end
    end
endmodule

// ### iafps_sequencer_tb.sv
// Testbench for the flash program sequencer: SFR tasks and checks.
// Assumes the design, the flash model and the checker beside it.
`timescale 1ns/100ps
module iafps_sequencer_tb;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg         sfrWr = 1'b0;
    reg         sfrRd = 1'b0;
    reg  [7:0]  sfrAddr = 8'h00;
    reg  [7:0]  sfrWdata = 8'h00;
    reg         extClkSel = 1'b1;
    reg         codeLock = 1'b0;
    reg         clkEn = 1'b1;
    wire [7:0]  sfrRdata, flashWdata, flashRdata;
    wire [15:0] flashAddr;
    wire        cpuHold, fastRcOscOn, flashRead, flashProgram, flashErase;
    integer     err_count = 0;
    integer     n_compared = 0;
    always #20 clk = ~clk;
    iafps_sequencer #(
        .PROG_CYC     (4),
        .ERASE_CYC    (6)
    ) iafps_sequencer_i (
        .clk          (clk),
        .reset        (reset),
        .clkEn        (clkEn),
        .sfrWr        (sfrWr),
        .sfrRd        (sfrRd),
        .sfrAddr      (sfrAddr),
        .sfrWdata     (sfrWdata),
        .sfrRdata     (sfrRdata),
        .extClkSel    (extClkSel),
        .codeLock     (codeLock),
        .cpuHold      (cpuHold),
        .fastRcOscOn  (fastRcOscOn),
        .flashAddr    (flashAddr),
        .flashWdata   (flashWdata),
        .flashRdata   (flashRdata),
        .flashRead    (flashRead),
        .flashProgram (flashProgram),
        .flashErase   (flashErase)
    );
    iafps_flash_model iafps_flash_model_i (
        .clk          (clk),
        .flashAddr    (flashAddr),
        .flashWdata   (flashWdata),
        .flashProgram (flashProgram),
        .flashErase   (flashErase),
        .flashRdata   (flashRdata)
    );
    // ========================================
    // Bus tasks
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            sfrRd = 1'b0;
            sfrWr = 1'b1;
            sfrAddr = a;
            sfrWdata = d;
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        begin
            @(negedge clk);
            sfrWr = 1'b0;
            sfrRd = 1'b1;
            sfrAddr = a;
            @(negedge clk);
            sfrRd = 1'b0;
            chk(sfrRdata, exp);
        end
    endtask
    task key;
        begin
            wr(8'hC7, 8'hAA);
            wr(8'hC7, 8'h55);
        end
    endtask
    task go;
        integer n;
        begin
            key;
            wr(8'hA4, 8'h01);
            @(negedge clk);
            sfrWr = 1'b0;
            @(negedge clk);
            for (n = 0; n < 200 && cpuHold === 1'b1; n = n + 1)
                @(negedge clk);
            if (n == 200) begin
                $display("ERROR %0t: operation never finished", $time);
                err_count = err_count + 1;
                wrap_up;
            end
        end
    endtask
    task wrap_up;
        begin
            if (err_count == 0 && n_compared > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // ========================================
    // Sequence
    initial begin
        repeat (2) @(negedge clk);
        reset = 1'b0;
        rd(8'hAE, 8'h00);
        rd(8'hA4, 8'h00);
        rd(8'hAF, 8'h30);
        rd(8'hA7, 8'h00);
        rd(8'h80, 8'h00);
        chk({7'h00, fastRcOscOn}, 8'h00);
        key;
        wr(8'h9F, 8'h01);
        rd(8'h9F, 8'h01);
        chk({7'h00, fastRcOscOn}, 8'h01);
        wr(8'hAF, 8'h00);
        wr(8'hA7, 8'h02);
        wr(8'hA6, 8'h81);
        go;
        rd(8'hAE, 8'h42);
        wr(8'hA6, 8'h00);
        wr(8'hA4, 8'h01);
        key;
        wr(8'hA6, 8'h01);
        wr(8'hA4, 8'h01);
        rd(8'hAE, 8'h42);
        key;
        wr(8'hA5, 8'h01);
        codeLock = 1'b1;
        wr(8'hAF, 8'h77);
        go;
        rd(8'h9F, 8'h41);
        key;
        wr(8'h9F, 8'h01);
        wr(8'hAF, 8'h22);
        wr(8'hA6, 8'h05);
        go;
        wr(8'hAF, 8'h21);
        wr(8'hA6, 8'h01);
        wr(8'hAE, 8'h55);
        go;
        wr(8'hAE, 8'h00);
        wr(8'hAF, 8'h00);
        go;
        rd(8'hAE, 8'h55);
        wr(8'hA6, 8'h7F);
        go;
        rd(8'hAE, 8'hFF);
        wr(8'hA6, 8'h80);
        go;
        rd(8'hAE, 8'h43);
        rd(8'h9F, 8'h01);
        key;
        wr(8'hA5, 8'h00);
        wr(8'hAF, 8'h21);
        go;
        rd(8'h9F, 8'h41);
        key;
        wr(8'h9F, 8'h00);
        rd(8'h9F, 8'h00);
        wr(8'hAF, 8'h00);
        wr(8'hA6, 8'h01);
        go;
        rd(8'hAE, 8'h43);
        chk({7'h00, fastRcOscOn}, 8'h00);
        // Frozen clock enable drops the write
        clkEn = 1'b0;
        wr(8'hAE, 8'h99);
        @(negedge clk);
        sfrWr = 1'b0;
        clkEn = 1'b1;
        rd(8'hAE, 8'h43);
        extClkSel = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h00, fastRcOscOn}, 8'h01);
        wrap_up;
    end
endmodule
bind iafps_sequencer iafps_seq_asserts #(
    .PROG_CYC     (PROG_CYC),
    .ERASE_CYC    (ERASE_CYC)
) iafps_seq_asserts_i (
    .clk          (clk),
    .reset        (reset),
    .sfrRd        (sfrRd),
    .sfrAddr      (sfrAddr),
    .sfrRdata     (sfrRdata),
    .extClkSel    (extClkSel),
    .cpuHold      (cpuHold),
    .fastRcOscOn  (fastRcOscOn),
    .flashAddr    (flashAddr),
    .flashRead    (flashRead),
    .flashProgram (flashProgram),
    .flashErase   (flashErase)
);
